// >>> gpio_ports.v
`timescale 1ns/1ps
`default_nettype none
`include "gpio_map.vh"

module gpio_ports #(
  parameter WF = 8,
  parameter WS = 7
) (
  // apb slave
  input  wire          pclk,
  input  wire          presetn,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [7:0]    paddr,
  input  wire [31:0]   pwdata,
  input  wire [3:0]    pstrb,
  output reg  [31:0]   prdata,
  output reg           pready,
  output reg           pslverr,
  // first port
  input  wire [WF-1:0] first_in,
  output wire [WF-1:0] first_out,
  output wire [WF-1:0] first_oe,
  output wire [WF-1:0] first_pull,
  // second port
  input  wire [WF-1:0] second_in,
  output wire [WF-1:0] second_out,
  output wire [WF-1:0] second_oe,
  output wire [WF-1:0] second_pull,
  // seven-bit port
  input  wire [WS-1:0] seven_in,
  output wire [WS-1:0] seven_out,
  output wire [WS-1:0] seven_oe,
  output wire [WS-1:0] seven_pull,
  // key-return port
  input  wire [WF-1:0] key_return_inputs,
  output wire [WF-1:0] key_out,
  output wire [WF-1:0] key_oe,
  output wire [WF-1:0] key_pull,
  // external interrupt request flag
  output reg           ext_interrupt_alt
);

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  reg  [7:0]    latch_first;
  reg  [7:0]    latch_second;
  reg  [7:0]    latch_seven;
  reg  [7:0]    latch_key;
  reg  [7:0]    dir_reg_first_port;
  reg  [7:0]    dir_reg_second_port;
  reg  [7:0]    dir_reg_seven_bit_port;
  reg  [7:0]    dir_reg_key_port;
  reg  [7:0]    pullup_option_reg;
  reg  [7:0]    drive_type_reg_a;
  reg  [7:0]    drive_type_reg_b;
  reg           ext_level_prev;
  reg  [31:0]   next_prdata;
  reg           next_pslverr;
  wire          wr_en;
  wire [7:0]    wd;
  wire          ext_driven;
  wire          ext_change;
  wire          ext_clear;

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  // input pins show the pad, output pins show the latch
  function [7:0] port_view;
    input [7:0] dir;
    input [7:0] pins;
    input [7:0] latch;
    begin
      port_view = (dir & pins) | (~dir & latch);
    end
  endfunction

  // ----------------------------------------------------------------------------
  // bus write strobe
  // ----------------------------------------------------------------------------
  // only the low byte lane carries register data
  assign wr_en = psel & penable & pready & pwrite & pstrb[0];
  assign wd    = pwdata[7:0];

  // ----------------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      latch_first            <= `RST_LATCH;
      latch_second           <= `RST_LATCH;
      latch_seven            <= `RST_LATCH;
      latch_key              <= `RST_LATCH;
      dir_reg_first_port     <= `RST_DIR;
      dir_reg_second_port    <= `RST_DIR;
      dir_reg_seven_bit_port <= `RST_DIR;
      dir_reg_key_port       <= `RST_DIR;
      pullup_option_reg      <= `RST_PULLUP;
      drive_type_reg_a       <= `RST_DRIVE;
      drive_type_reg_b       <= `RST_DRIVE;
    end
    else if (wr_en)
    begin
      case (paddr)
        `OFS_DATA_FIRST:  latch_first  <= wd;
        `OFS_DATA_SECOND: latch_second <= wd;
        `OFS_DATA_SEVEN:  latch_seven  <= {1'b0, wd[6:0]};
        `OFS_DATA_KEY:    latch_key    <= wd;
        `OFS_DIR_FIRST:   dir_reg_first_port     <= wd;
        `OFS_DIR_SECOND:  dir_reg_second_port    <= wd;
        `OFS_DIR_SEVEN:   dir_reg_seven_bit_port <= wd;
        `OFS_DIR_KEY:     dir_reg_key_port       <= wd;
        `OFS_PULLUP:      pullup_option_reg      <= wd;
        `OFS_DRIVE_A:     drive_type_reg_a       <= wd;
        `OFS_DRIVE_B:     drive_type_reg_b       <= wd;
        default:          latch_first            <= latch_first;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // external interrupt flag
  // ----------------------------------------------------------------------------
  // the pin also feeds the interrupt input, so own drive changes look like edges
  assign ext_driven = ~dir_reg_seven_bit_port[`EXT_PIN];
  assign ext_change = ext_driven & (latch_seven[`EXT_PIN] != ext_level_prev);
  assign ext_clear  = wr_en & (paddr == `OFS_EXT_FLAG) & wd[`EXT_FLAG_BIT];

  // set wins over a clear in the same cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_level_prev    <= 1'b0;
      ext_interrupt_alt <= 1'b0;
    end
    else
    begin
      ext_level_prev <= latch_seven[`EXT_PIN];
      if (ext_change)
        ext_interrupt_alt <= 1'b1;
      else if (ext_clear)
        ext_interrupt_alt <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------------
  always @*
  begin
    next_prdata  = 32'h00000000;
    next_pslverr = 1'b0;
    case (paddr)
      `OFS_DATA_FIRST:  next_prdata[7:0] = port_view(dir_reg_first_port, first_in, latch_first);
      `OFS_DATA_SECOND: next_prdata[7:0] = port_view(dir_reg_second_port, second_in, latch_second);
      `OFS_DATA_SEVEN:  next_prdata[7:0] = port_view(dir_reg_seven_bit_port, {1'b0, seven_in}, latch_seven)
                                          & 8'h7F;
      `OFS_DATA_KEY:    next_prdata[7:0] = port_view(dir_reg_key_port, key_return_inputs, latch_key);
      `OFS_DIR_FIRST:   next_prdata[7:0] = dir_reg_first_port;
      `OFS_DIR_SECOND:  next_prdata[7:0] = dir_reg_second_port;
      `OFS_DIR_SEVEN:   next_prdata[7:0] = dir_reg_seven_bit_port;
      `OFS_DIR_KEY:     next_prdata[7:0] = dir_reg_key_port;
      `OFS_PULLUP:      next_prdata[7:0] = pullup_option_reg;
      `OFS_DRIVE_A:     next_prdata[7:0] = drive_type_reg_a;
      `OFS_DRIVE_B:     next_prdata[7:0] = drive_type_reg_b;
      `OFS_EXT_FLAG:    next_prdata[0]   = ext_interrupt_alt;
      default:          next_pslverr     = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------------------
  // apb answer
  // ----------------------------------------------------------------------------
  // data captured in setup so pready and prdata both come from flops;
  // the access phase always lasts exactly one cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & next_pslverr;
      if (psel & ~penable & ~pwrite)
        prdata <= next_prdata;
      else
        prdata <= 32'h00000000;
    end
  end

  // ----------------------------------------------------------------------------
  // pad cells
  // ----------------------------------------------------------------------------
  // 31 pins, 18 open-drain capable
  port_pins #(.W(WF)) u_first (
    .pclk       (pclk),
    .presetn    (presetn),
    .latch      (latch_first[WF-1:0]),
    .dir        (dir_reg_first_port[WF-1:0]),
    .open_drain ({WF{drive_type_reg_a[`DRV_A_BIT_FIRST]}}),
    .pullup_sel (pullup_option_reg[`PU_BIT_FIRST]),
    .pin_out    (first_out),
    .pin_oe     (first_oe),
    .pull_en    (first_pull)
  );

  port_pins #(.W(WF)) u_second (
    .pclk       (pclk),
    .presetn    (presetn),
    .latch      (latch_second[WF-1:0]),
    .dir        (dir_reg_second_port[WF-1:0]),
    .open_drain ({WF{drive_type_reg_a[`DRV_A_BIT_SECOND]}}),
    .pullup_sel (pullup_option_reg[`PU_BIT_SECOND]),
    .pin_out    (second_out),
    .pin_oe     (second_oe),
    .pull_en    (second_pull)
  );

  port_pins #(.W(WS)) u_seven (
    .pclk       (pclk),
    .presetn    (presetn),
    .latch      (latch_seven[WS-1:0]),
    .dir        (dir_reg_seven_bit_port[WS-1:0]),
    .open_drain ({drive_type_reg_b[`DRV_B_BIT_PIN6:`DRV_B_BIT_PIN5], 5'b00000}),
    .pullup_sel (pullup_option_reg[`PU_BIT_SEVEN]),
    .pin_out    (seven_out),
    .pin_oe     (seven_oe),
    .pull_en    (seven_pull)
  );

  port_pins #(.W(WF)) u_key (
    .pclk       (pclk),
    .presetn    (presetn),
    .latch      (latch_key[WF-1:0]),
    .dir        (dir_reg_key_port[WF-1:0]),
    .open_drain ({WF{1'b0}}),
    .pullup_sel (pullup_option_reg[`PU_BIT_KEY]),
    .pin_out    (key_out),
    .pin_oe     (key_oe),
    .pull_en    (key_pull)
  );

endmodule

`default_nettype wire

// >>> gpio_map.vh
`ifndef GPIO_MAP_VH
`define GPIO_MAP_VH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define OFS_DATA_FIRST   8'h00
`define OFS_DATA_SECOND  8'h04
`define OFS_DATA_SEVEN   8'h08
`define OFS_DATA_KEY     8'h0C
`define OFS_DIR_FIRST    8'h10
`define OFS_DIR_SECOND   8'h14
`define OFS_DIR_SEVEN    8'h18
`define OFS_DIR_KEY      8'h1C
`define OFS_PULLUP       8'h20
`define OFS_DRIVE_A      8'h24
`define OFS_DRIVE_B      8'h28
`define OFS_EXT_FLAG     8'h2C

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define PU_BIT_FIRST     0
`define PU_BIT_SECOND    1
`define PU_BIT_SEVEN     2
`define PU_BIT_KEY       4
`define DRV_A_BIT_FIRST  0
`define DRV_A_BIT_SECOND 1
`define DRV_B_BIT_PIN5   5
`define DRV_B_BIT_PIN6   6
`define EXT_PIN          6
`define EXT_FLAG_BIT     0

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define RST_DIR          8'hFF
`define RST_LATCH        8'h00
`define RST_PULLUP       8'h00
`define RST_DRIVE        8'h00

`endif

// >>> port_pins.v
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// pin cell: turns latch, direction, drive type and pull-up into pad controls
// ----------------------------------------------------------------------------
module port_pins #(
  parameter W = 8
) (
  // clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // settings
  input  wire [W-1:0] latch,
  input  wire [W-1:0] dir,
  input  wire [W-1:0] open_drain,
  input  wire         pullup_sel,
  // pad controls
  output reg  [W-1:0] pin_out,
  output reg  [W-1:0] pin_oe,
  output reg  [W-1:0] pull_en
);

  // ----------------------------------------------------------------------------
  // registered pad drive
  // ----------------------------------------------------------------------------
  // open-drain pins only pull low, so the enable follows a zero latch bit
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_out <= {W{1'b0}};
      pin_oe  <= {W{1'b0}};
      pull_en <= {W{1'b0}};
    end
    else
    begin
      pin_out <= latch & ~open_drain;
      pin_oe  <= ~dir & (~open_drain | ~latch);
      pull_en <= dir & {W{pullup_sel}};
    end
  end

endmodule

`default_nettype wire

// >>> gpio_ports_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// apb and pad checker
// ----------------------------------------------------------------------------
module gpio_ports_sva #(
  parameter WF = 8
) (
  // apb side
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [7:0]    paddr,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  // pads and flag
  input wire logic [WF-1:0] first_oe,
  input wire logic [WF-1:0] first_pull,
  input wire logic [WF-1:0] key_oe,
  input wire logic [WF-1:0] key_pull,
  input wire logic          ext_interrupt_alt
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // transfer phases
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence unmapped_s;
    setup_s ##1 (paddr >= 8'h30);
  endsequence

  rdy_after_setup_a: assert property (setup_s |=> pready)
    else $error("no ready after setup");
  rdy_cause_a: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("ready without setup");
  err_unmapped_a: assert property (unmapped_s |-> pready && pslverr)
    else $error("unmapped access not refused");
  err_only_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  pull_first_a: assert property ((first_pull & first_oe) == '0)
    else $error("pull-up on driven first pin");
  pull_key_a: assert property ((key_pull & key_oe) == '0)
    else $error("pull-up on driven key pin");
  reset_input_a: assert property ($rose(presetn) |-> first_oe == '0 && key_oe == '0)
    else $error("pin driven after reset");
  flag_sticky_a: assert property (ext_interrupt_alt && !(psel && penable && pwrite) |=> ext_interrupt_alt)
    else $error("flag dropped without write");
endmodule

bind gpio_ports gpio_ports_sva #(.WF(WF)) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .first_oe(first_oe), .first_pull(first_pull),
  .key_oe(key_oe), .key_pull(key_pull), .ext_interrupt_alt(ext_interrupt_alt)
);
`default_nettype wire

// >>> general_purpose_io_ports_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// port block bench
// ----------------------------------------------------------------------------
module general_purpose_io_ports_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  logic [3:0]  pstrb = 4'hF;
  logic [7:0]  first_in = 8'h3C, second_in = 8'h96, key_in = 8'h00;
  logic [6:0]  seven_in = 7'h00;
  wire  [31:0] prdata;
  wire         pready, pslverr, ext_flag;
  wire  [7:0]  f_out, f_oe, f_pull, s_out, s_oe, s_pull, k_out, k_oe, k_pull;
  wire  [6:0]  v_out, v_oe, v_pull;
  int          n_fail = 0, num_checks = 0;

  always #2.5 pclk = ~pclk;

  gpio_ports dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .first_in(first_in), .first_out(f_out), .first_oe(f_oe), .first_pull(f_pull),
    .second_in(second_in), .second_out(s_out), .second_oe(s_oe), .second_pull(s_pull),
    .seven_in(seven_in), .seven_out(v_out), .seven_oe(v_oe), .seven_pull(v_pull),
    .key_return_inputs(key_in), .key_out(k_out), .key_oe(k_oe), .key_pull(k_pull),
    .ext_interrupt_alt(ext_flag)
  );

  // ----------------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; idle edge first so psel never changes twice at one edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // answer, read data and error are all taken at the edge that sees pready high
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // pads follow a register one edge later
  task automatic settle;
    @(posedge pclk);
    #1;
  endtask

  task automatic close_out;
    if (n_fail == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  // reset state
  task automatic t_reset;
    chk(f_oe | s_oe | k_oe | v_oe, 0);
    for (int i = 0; i < 4; i++)
    begin
      apb(0, 8'h10 + 8'(4 * i), 0);
      chk(rd, 32'hFF);
    end
  endtask

  task automatic t_first;
    apb(1, 8'h00, 32'hA5);
    apb(1, 8'h10, 32'hF0);
    settle;
    chk(f_oe, 8'h0F);
    chk(f_out, 8'hA5);
    apb(0, 8'h00, 0);
    chk(rd, 32'h35);
    apb(1, 8'h24, 32'h01);
    settle;
    chk(f_out, 8'h00);
    chk(f_oe, 8'h0A);
  endtask

  task automatic t_pull;
    apb(1, 8'h14, 32'h0F);
    apb(1, 8'h04, 32'h5A);
    apb(1, 8'h20, 32'h17);
    settle;
    chk(s_oe, 8'hF0);
    chk(s_out, 8'h5A);
    chk(s_pull, 8'h0F);
    chk(f_pull, 8'hF0);
    chk(v_pull, 7'h7F);
    chk(k_pull, 8'hFF);
    apb(0, 8'h04, 0);
    chk(rd, 32'h56);
    apb(1, 8'h20, 32'h02);
    settle;
    chk(k_pull, 0);
  endtask

  task automatic t_seven;
    apb(1, 8'h28, 32'h20);
    apb(1, 8'h18, 32'h00);
    settle;
    chk(v_oe, 7'h7F);
    chk(ext_flag, 0);
    apb(1, 8'h08, 32'h7F);
    settle;
    chk(v_out, 7'h5F);
    chk(v_oe, 7'h5F);
    chk(ext_flag, 1);
    apb(1, 8'h2C, 32'h01);
    apb(0, 8'h2C, 0);
    chk(rd, 0);
  endtask

  // key port, masked write, unmapped place
  task automatic t_key;
    apb(1, 8'h1C, 0);
    apb(1, 8'h0C, 32'hC3);
    settle;
    chk(k_out, 8'hC3);
    chk(k_oe, 8'hFF);
    @(posedge pclk);
    pstrb <= 4'h0;
    apb(1, 8'h0C, 0);
    pstrb <= 4'hF;
    apb(0, 8'h0C, 0);
    chk(rd, 32'hC3);
    apb(0, 8'h30, 0);
    chk({rd[30:0], err}, 1);
  endtask

  // reset in mid-run undoes the settings made so far
  task automatic t_rerun;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk(f_oe | s_oe | k_oe | v_oe, 0);
    apb(0, 8'h1C, 0);
    chk(rd, 32'hFF);
    apb(0, 8'h24, 0);
    chk(rd, 32'h00);
  endtask

  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_first;
    t_pull;
    t_seven;
    t_key;
    t_rerun;
    close_out;
  end

  // watchdog well beyond the hundred or so cycles needed
  initial
  begin
    #20000;
    n_fail++;
    close_out;
  end
endmodule
`default_nettype wire
